// ---- hdl/gpio_port_pkg.sv ----
// Package: register map, field layout, reset values and sensitivity encodings of the GPIO port
package gpio_port_pkg;

	// ==========================================================================
	// Register byte addresses
	localparam logic [7:0] ADDR_PORT_PIN_DATA  = 8'h00;
	localparam logic [7:0] ADDR_PORT_DIRECTION = 8'h04;
	localparam logic [7:0] ADDR_PORT_OPTION    = 8'h08;
	localparam logic [7:0] ADDR_INT_SENSE      = 8'h0C;
	localparam logic [7:0] ADDR_INT_STATUS     = 8'h10;

	// ==========================================================================
	// Reset values
	localparam logic [7:0] RST_PORT_REG  = 8'h00;
	localparam logic [1:0] RST_INT_SENSE = 2'h0;

	// ==========================================================================
	// Status register fields
	localparam int STAT_PENDING_BIT = 0;
	localparam int STAT_GMASK_BIT   = 1;

	// ==========================================================================
	// Sensitivity encodings
	typedef enum logic [1:0] {
		SENSE_FALL_LOW = 2'h0,
		SENSE_RISE     = 2'h1,
		SENSE_FALL     = 2'h2,
		SENSE_BOTH     = 2'h3
	} ext_int_sensitivity_t;

	// ==========================================================================
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- hdl/gpio_pin_sync.sv ----
// Two-stage synchroniser for the asynchronous pin levels
module gpio_pin_sync
	import gpio_port_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_clk_en,
	// Data
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] stage1;

	if (WIDTH < 1) begin : bad_width
		$error("gpio_pin_sync: WIDTH must be at least 1");
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stage1 <= '0;
			o_sync <= '0;
		end else if (i_clk_en) begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end

endmodule

// ---- hdl/gpio_port_with_ext_interrupt.sv ----
// GPIO port with per-pin direction, option, alternate functions and external interrupt
module gpio_port_with_ext_interrupt
	import gpio_port_pkg::*;
#(
	parameter int          PINS     = 8,
	parameter logic [7:0]  INT_PINS = 8'hFF
) (
	// Clock, reset, enable
	input  wire logic            i_sys_clk,
	input  wire logic            i_rst_n,
	input  wire logic            i_clk_en,
	// AXI4-Lite write address
	input  wire logic [7:0]      i_awaddr,
	input  wire logic            i_awvalid,
	output logic                 o_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]     i_wdata,
	input  wire logic [3:0]      i_wstrb,
	input  wire logic            i_wvalid,
	output logic                 o_wready,
	// AXI4-Lite write response
	output logic [1:0]           o_bresp,
	output logic                 o_bvalid,
	input  wire logic            i_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]      i_araddr,
	input  wire logic            i_arvalid,
	output logic                 o_arready,
	// AXI4-Lite read data
	output logic [31:0]          o_rdata,
	output logic [1:0]           o_rresp,
	output logic                 o_rvalid,
	input  wire logic            i_rready,
	// Pins
	input  wire logic [PINS-1:0] i_pin,
	output logic [PINS-1:0]      o_pin,
	output logic [PINS-1:0]      o_pin_oe_n,
	output logic [PINS-1:0]      o_pull_up_en,
	// On-chip peripherals
	input  wire logic [PINS-1:0] i_alt_out_en,
	input  wire logic [PINS-1:0] i_alt_out,
	input  wire logic [PINS-1:0] i_alt_open_drain,
	input  wire logic [PINS-1:0] i_alt_in_en,
	output logic [PINS-1:0]      o_alt_in,
	// CPU interrupt side
	input  wire logic            i_cpu_int_mask,
	input  wire logic            i_vector_fetch,
	output logic                 o_ext_int_req,
	output logic                 o_wakeup
);

	if (PINS < 1 || PINS > 8) begin : bad_pins
		$error("gpio_port: PINS must be 1 to 8");
	end

	// ==========================================================================
	// Registers
	logic [PINS-1:0]      data_latch;
	logic [PINS-1:0]      port_direction;
	logic [PINS-1:0]      port_option;
	ext_int_sensitivity_t ext_int_sensitivity;
	logic [PINS-1:0]      pin_level;
	logic [PINS-1:0]      pin_level_d;
	logic                 int_pending;

	function automatic logic [PINS-1:0] merge_bits(input logic [PINS-1:0] old_v,
			input logic [31:0] wd, input logic [3:0] strb);
		merge_bits = strb[0] ? wd[PINS-1:0] : old_v;
	endfunction

	// ==========================================================================
	// Pin synchroniser
	gpio_pin_sync #(.WIDTH (PINS)) gpio_pin_sync_inst (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_clk_en  (i_clk_en),
		.i_async   (i_pin),
		.o_sync    (pin_level)
	);

	// ==========================================================================
	// Write channel: address and data taken in either order
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_fire;
	logic        wr_hit;
	assign wr_fire = aw_held && w_held && !o_bvalid;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr   <= 8'h00;
			w_data    <= 32'h0;
			w_strb    <= 4'h0;
			o_awready <= 1'b0;
			o_wready  <= 1'b0;
			o_bvalid  <= 1'b0;
			o_bresp   <= RESP_OKAY;
		end else if (i_clk_en) begin
			o_awready <= !aw_held && !(i_awvalid && o_awready);
			o_wready  <= !w_held && !(i_wvalid && o_wready);
			if (i_awvalid && o_awready) begin
				aw_held <= 1'b1;
				aw_addr <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_held <= 1'b1;
				w_data <= i_wdata;
				w_strb <= i_wstrb;
			end
			if (wr_fire) begin
				aw_held  <= 1'b0;
				w_held   <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	assign wr_hit = aw_addr inside {ADDR_PORT_PIN_DATA, ADDR_PORT_DIRECTION, ADDR_PORT_OPTION,
		ADDR_INT_SENSE, ADDR_INT_STATUS};

	// ==========================================================================
	// Register writes; only the latch changes, pin follows direction
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			data_latch     <= RST_PORT_REG[PINS-1:0];
			port_direction <= RST_PORT_REG[PINS-1:0];
			port_option    <= RST_PORT_REG[PINS-1:0];
		end else if (i_clk_en && wr_fire) begin
			case (aw_addr)
				ADDR_PORT_PIN_DATA:  data_latch     <= merge_bits(data_latch, w_data, w_strb);
				ADDR_PORT_DIRECTION: port_direction <= merge_bits(port_direction, w_data, w_strb);
				ADDR_PORT_OPTION:    port_option    <= merge_bits(port_option, w_data, w_strb);
				default: ;
			endcase
		end
	end

	logic sense_write;
	assign sense_write = wr_fire && aw_addr == ADDR_INT_SENSE && w_strb[0];

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ext_int_sensitivity <= ext_int_sensitivity_t'(RST_INT_SENSE);
		end else if (i_clk_en && sense_write) begin
			ext_int_sensitivity <= ext_int_sensitivity_t'(w_data[1:0]);
		end
	end

	// ==========================================================================
	// Pin drive: alternate output overrides DDR, OR and latch
	logic [PINS-1:0] drive_val;
	logic [PINS-1:0] drive_en;
	logic [PINS-1:0] is_int_in;

	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			if (i_alt_out_en[i]) begin
				drive_val[i] = i_alt_out[i];
				drive_en[i]  = !(i_alt_open_drain[i] && i_alt_out[i]);
			end else if (port_direction[i]) begin
				drive_val[i] = data_latch[i];
				drive_en[i]  = port_option[i] || !data_latch[i];
			end else begin
				drive_val[i] = 1'b0;
				drive_en[i]  = 1'b0;
			end
		end
	end

	// Interrupt pins: input not claimed by alternate output, option set, interrupt-capable
	assign is_int_in = ~port_direction & port_option & INT_PINS[PINS-1:0] & ~i_alt_out_en;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pin        <= '0;
			o_pin_oe_n   <= '1;
			o_pull_up_en <= '0;
			o_alt_in     <= '0;
		end else if (i_clk_en) begin
			o_pin        <= drive_val;
			o_pin_oe_n   <= ~drive_en;
			// Pull-up only on plain inputs with option set; floating otherwise
			o_pull_up_en <= ~port_direction & port_option & ~i_alt_out_en;
			// Output pin feeds latch to peripheral input; input pin feeds pin
			o_alt_in     <= i_alt_in_en & ((port_direction & data_latch) |
				(~port_direction & pin_level));
		end
	end

	// ==========================================================================
	// External interrupt: qualify per pin, OR, latch
	logic [PINS-1:0] qual;
	logic            any_event;

	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			case (ext_int_sensitivity)
				SENSE_FALL_LOW: qual[i] = !pin_level[i] || (pin_level_d[i] && !pin_level[i]);
				SENSE_RISE:     qual[i] = pin_level[i] && !pin_level_d[i];
				SENSE_FALL:     qual[i] = !pin_level[i] && pin_level_d[i];
				SENSE_BOTH:     qual[i] = pin_level[i] != pin_level_d[i];
				default:        qual[i] = 1'b0;
			endcase
		end
	end
	assign any_event = |(qual & is_int_in);

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_level_d <= '0;
		end else if (i_clk_en) begin
			pin_level_d <= pin_level;
		end
	end

	// Event wins over vector fetch; a sensitivity write discards all pending
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			int_pending <= 1'b0;
		end else if (i_clk_en) begin
			if (sense_write) begin
				int_pending <= 1'b0;
			end else if (any_event) begin
				int_pending <= 1'b1;
			end else if (i_vector_fetch) begin
				int_pending <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ext_int_req <= 1'b0;
			o_wakeup      <= 1'b0;
		end else if (i_clk_en) begin
			o_ext_int_req <= int_pending && !i_cpu_int_mask && !sense_write;
			// Wake is independent of the mask: low power forces it open anyway
			o_wakeup      <= int_pending && !sense_write;
		end
	end

	// ==========================================================================
	// Read channel
	logic [PINS-1:0] data_read;

	// Input pins read pin level, or peripheral output when claimed
	assign data_read = (port_direction & data_latch) |
		(~port_direction & i_alt_out_en & i_alt_out) |
		(~port_direction & ~i_alt_out_en & pin_level);

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0;
			o_rresp   <= RESP_OKAY;
		end else if (i_clk_en) begin
			o_arready <= !o_rvalid && !(i_arvalid && o_arready);
			if (i_arvalid && o_arready) begin
				o_rvalid <= 1'b1;
				o_rresp  <= RESP_OKAY;
				o_rdata  <= 32'h0;
				case (i_araddr)
					ADDR_PORT_PIN_DATA:  o_rdata[PINS-1:0] <= data_read;
					ADDR_PORT_DIRECTION: o_rdata[PINS-1:0] <= port_direction;
					ADDR_PORT_OPTION:    o_rdata[PINS-1:0] <= port_option;
					ADDR_INT_SENSE:      o_rdata[1:0]      <= ext_int_sensitivity;
					ADDR_INT_STATUS: begin
						o_rdata[STAT_PENDING_BIT] <= int_pending;
						o_rdata[STAT_GMASK_BIT]   <= i_cpu_int_mask;
					end
					default: o_rresp <= RESP_SLVERR;
				endcase
			end else if (o_rvalid && i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================================
	// Assertions
	AST_SENSE_DISCARD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_clk_en && sense_write |=> !int_pending) else $error("pending not discarded");
	AST_MASK_BLOCKS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_clk_en && i_cpu_int_mask |=> !o_ext_int_req) else $error("request passed mask");
	AST_EVENT_SETS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_clk_en && any_event && !sense_write |=> int_pending) else $error("event lost");
	AST_FETCH_CLEARS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_clk_en && i_vector_fetch && !any_event |=> !int_pending) else $error("fetch kept req");
	AST_OD_RELEASE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_clk_en && port_direction[1] && !port_option[1] && data_latch[1] && !i_alt_out_en[1]
		|=> o_pin_oe_n[1]) else $error("open-drain drove high");
	AST_PP_DRIVE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_clk_en && port_direction[4] && port_option[4] && !i_alt_out_en[4]
		|=> !o_pin_oe_n[4] && o_pin[4] == $past(data_latch[4])) else $error("push-pull wrong");
	AST_ALT_OVERRIDE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_clk_en && i_alt_out_en[0] && !i_alt_open_drain[0]
		|=> !o_pin_oe_n[0] && o_pin[0] == $past(i_alt_out[0])) else $error("alt not driven");
	AST_INPUT_FLOATS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_clk_en && !port_direction[0] && !i_alt_out_en[0] |=> o_pin_oe_n[0])
		else $error("input pin driven");
	AST_SYNC_DELAY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_clk_en [*3] |-> pin_level == $past(i_pin, 2)) else $error("sync depth wrong");

endmodule

// ---- testbench/gpio_board_model.sv ----
// Board model: resolves the pin levels that the port sees
module gpio_board_model (
	// Clock
	input  wire logic       i_sys_clk,
	// Device side
	input  wire logic [7:0] i_pin_out,
	input  wire logic [7:0] i_oe_n,
	input  wire logic [7:0] i_pull_up,
	// Bench side
	input  wire logic [7:0] i_ext_en,
	input  wire logic [7:0] i_ext_val,
	output logic      [7:0] o_level
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================================
	// Floating level
	logic tog = 1'b0;

	// A released pin without pull-up wanders, so a stale value never passes
	always @(posedge i_sys_clk) begin
		tog <= ~tog;
	end

	// ==========================================================================
	// Wire resolution
	// Bench drive wins on every pin with ext_en set, whether or not the port has released it
	assign o_level = (i_ext_en & i_ext_val) | (~i_ext_en & ~i_oe_n & i_pin_out)
		| (~i_ext_en & i_oe_n & (i_pull_up | {8{tog}}));
endmodule

// ---- testbench/gpio_port_with_ext_interrupt_bench.sv ----
// Bench: register bus, pin modes, peripheral overrides and external interrupt
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module gpio_port_with_ext_interrupt_bench
	import gpio_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================================
	// Signals
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        clk_en = 1'b1;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hF;
	logic [7:0]  ext_en = 8'h00, ext_val = 8'h00, alt_out_en = 8'h00;
	logic [7:0]  alt_out = 8'h00, alt_od = 8'h00, alt_in_en = 8'h00;
	logic        int_mask = 1'b0, vec_fetch = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, req, wake;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [7:0]  pin_out, oe_n, pull_up, alt_in, pin_lvl;
	int          num_errors = 0;
	int          n_tests = 0;
	int          n;

	always #2 sys_clk = ~sys_clk;

	gpio_port_with_ext_interrupt gpio_port_with_ext_interrupt_inst (
		.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_clk_en(clk_en),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
		.i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
		.i_pin(pin_lvl), .o_pin(pin_out), .o_pin_oe_n(oe_n), .o_pull_up_en(pull_up),
		.i_alt_out_en(alt_out_en), .i_alt_out(alt_out), .i_alt_open_drain(alt_od),
		.i_alt_in_en(alt_in_en), .o_alt_in(alt_in),
		.i_cpu_int_mask(int_mask), .i_vector_fetch(vec_fetch),
		.o_ext_int_req(req), .o_wakeup(wake));

	gpio_board_model gpio_board_model_inst (
		.i_sys_clk(sys_clk), .i_pin_out(pin_out), .i_oe_n(oe_n), .i_pull_up(pull_up),
		.i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(pin_lvl));

	// ==========================================================================
	// Closing and bus tasks
	task automatic complete_run();
		if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic hang();
		num_errors++;
		complete_run();
	endtask

	task automatic wrc(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge sys_clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h0, d};
		wvalid <= 1'b1;
		bready <= 1'b1;
		repeat (50) begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				`CHK("bresp", er, bresp)
				return;
			end
		end
		hang();
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		repeat (50) begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				`CHK("rdata", e, rdata)
				`CHK("rresp", er, rresp)
				return;
			end
		end
		hang();
	endtask

	// ==========================================================================
	// Scenarios
	task automatic t_reset();
		`CHK("oe_n", 8'hFF, oe_n)
		rdc(ADDR_PORT_DIRECTION, 32'h0, RESP_OKAY);
		rdc(ADDR_PORT_OPTION, 32'h0, RESP_OKAY);
		// Lane 0 strobe low: the word must leave the register alone
		wstrb <= 4'hE;
		wrc(ADDR_PORT_OPTION, 8'hFF, RESP_OKAY);
		wstrb <= 4'hF;
		rdc(ADDR_PORT_OPTION, 32'h0, RESP_OKAY);
		rdc(8'h20, 32'h0, RESP_SLVERR);
		wrc(8'h20, 8'hFF, RESP_SLVERR);
	endtask

	task automatic t_input();
		ext_en <= 8'hFF;
		ext_val <= 8'hA5;
		// Whole-word latch write, never a read-modify-write of input bits
		wrc(ADDR_PORT_PIN_DATA, 8'h5A, RESP_OKAY);
		repeat (4) @(posedge sys_clk);
		rdc(ADDR_PORT_PIN_DATA, 32'hA5, RESP_OKAY);
		`CHK("oe_n", 8'hFF, oe_n)
		`CHK("pull_up", 8'h00, pull_up)
	endtask

	task automatic t_output();
		// Pin 7 open-drain, so it can later sit as a plain input while claimed
		wrc(ADDR_PORT_OPTION, 8'h70, RESP_OKAY);
		ext_en <= 8'h00;
		wrc(ADDR_PORT_DIRECTION, 8'hFF, RESP_OKAY);
		repeat (2) @(posedge sys_clk);
		`CHK("oe_n", 8'h0A, oe_n)
		`CHK("pin", 8'h50, pin_out & ~oe_n)
		rdc(ADDR_PORT_PIN_DATA, 32'h5A, RESP_OKAY);
		alt_in_en <= 8'hFF;
		repeat (2) @(posedge sys_clk);
		`CHK("alt_in", 8'h5A, alt_in)
	endtask

	task automatic t_alt();
		alt_out_en <= 8'h81;
		alt_out <= 8'h81;
		alt_od <= 8'h80;
		repeat (2) @(posedge sys_clk);
		`CHK("oe_n", 8'h8A, oe_n)
		`CHK("pin0", 1'b1, pin_out[0])
		// Claimed pins 0 and 7 turn input without interrupt
		wrc(ADDR_PORT_DIRECTION, 8'h7E, RESP_OKAY);
		rdc(ADDR_PORT_PIN_DATA, 32'hDB, RESP_OKAY);
		alt_out_en <= 8'h00;
		wrc(ADDR_PORT_DIRECTION, 8'h00, RESP_OKAY);
		ext_en <= 8'hFF;
		ext_val <= 8'h3C;
		repeat (4) @(posedge sys_clk);
		rdc(ADDR_PORT_PIN_DATA, 32'h3C, RESP_OKAY);
		`CHK("alt_in", 8'h3C, alt_in)
		`CHK("pull_up", 8'h70, pull_up)
	endtask

	task automatic t_int();
		alt_in_en <= 8'h00;
		ext_val <= 8'h00;
		wrc(ADDR_PORT_OPTION, 8'h03, RESP_OKAY);
		// Codes 3, 2 and 1 must stick; pins sit low so the last write must be rise
		for (int i = 3; i >= 1; i--) begin
			wrc(ADDR_INT_SENSE, 8'(i), RESP_OKAY);
			rdc(ADDR_INT_SENSE, 32'(i), RESP_OKAY);
		end
		repeat (4) @(posedge sys_clk);
		`CHK("wake", 1'b0, wake)
		ext_val <= 8'h02;
		for (n = 0; n < 8 && req !== 1'b1; n++) @(posedge sys_clk);
		`CHK("req", 1'b1, req)
		if (req !== 1'b1) hang();
		`CHK("wake", 1'b1, wake)
		vec_fetch <= 1'b1;
		@(posedge sys_clk);
		vec_fetch <= 1'b0;
		repeat (3) @(posedge sys_clk);
		`CHK("req", 1'b0, req)
		int_mask <= 1'b1;
		ext_val <= 8'h03;
		repeat (6) @(posedge sys_clk);
		`CHK("wake", 1'b1, wake)
		`CHK("req", 1'b0, req)
		rdc(ADDR_INT_STATUS, 32'h3, RESP_OKAY);
		wrc(ADDR_INT_SENSE, 8'(SENSE_RISE), RESP_OKAY);
		ext_val <= 8'h83;
		repeat (6) @(posedge sys_clk);
		`CHK("wake", 1'b0, wake)
		wrc(ADDR_INT_SENSE, 8'(SENSE_FALL), RESP_OKAY);
		ext_val <= 8'h81;
		repeat (6) @(posedge sys_clk);
		`CHK("wake", 1'b1, wake)
	endtask

	task automatic t_freeze();
		// Enable low: a pulse on pin 0 must leave no trace in the synchroniser
		wrc(ADDR_INT_SENSE, 8'(SENSE_RISE), RESP_OKAY);
		clk_en <= 1'b0;
		ext_val <= 8'h80;
		repeat (4) @(posedge sys_clk);
		ext_val <= 8'h81;
		repeat (4) @(posedge sys_clk);
		clk_en <= 1'b1;
		repeat (6) @(posedge sys_clk);
		`CHK("wake", 1'b0, wake)
		rdc(ADDR_INT_SENSE, 32'(SENSE_RISE), RESP_OKAY);
	endtask

	// ==========================================================================
	// Main sequence
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_input();
		t_output();
		t_alt();
		t_int();
		t_freeze();
		complete_run();
	end

	// Limit on the whole run
	initial begin
		repeat (20000) @(posedge sys_clk);
		hang();
	end
endmodule
